// File: trd_core.sv
// touch and release decision core for eight sense inputs
`timescale 1ns/10ps
module trd_core
    import trd_pkg::*;
#(
    parameter int N = trd_pkg::NUM_SENSORS,
    parameter int TW = trd_pkg::TICK_W,
    parameter int CYC_PER_SEC = trd_pkg::CYCLES_PER_SECOND
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    output logic [7:0] reg_rdata,
    // sensing inputs
    input wire logic scan_sample,
    input wire logic [N*TW-1:0] sample_ticks,
    input wire logic [N*8-1:0] per_pin_touch_threshold,
    input wire logic [N*trd_pkg::SENS_W-1:0] sensitivity_pairs,
    input wire logic [7:0] sensing_misc_control,
    input wire logic [3:0] periodic_recal_interval,
    // results
    output logic [N-1:0] button_state,
    output logic button_irq,
    output logic [N-1:0] average_hold,
    output logic recal_request
);
    import trd_pkg::*;

    // ==========================================================
    // registers
    logic [7:0] button_config_ff;
    logic [7:0] average_hold_threshold_ff;
    logic [7:0] negative_recal_threshold_ff;
    logic [7:0] negative_recal_count_limit_ff;
    logic [7:0] touch_hysteresis_percent_ff;
    logic [7:0] held_touch_timeout_ff;
    logic [7:0] rdata_ff;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            button_config_ff <= RST_BUTTON_CONFIG;
            average_hold_threshold_ff <= RST_AVG_HOLD_THR;
            negative_recal_threshold_ff <= RST_NEG_RECAL_THR;
            negative_recal_count_limit_ff <= RST_NEG_RECAL_LIMIT;
            touch_hysteresis_percent_ff <= RST_HYST_PERCENT;
            held_touch_timeout_ff <= RST_HELD_TIMEOUT;
        end else if (reg_wr) begin
            case (reg_addr)
                ADDR_BUTTON_CONFIG: button_config_ff <= reg_wdata;
                ADDR_AVG_HOLD_THR: average_hold_threshold_ff <= reg_wdata;
                ADDR_NEG_RECAL_THR: negative_recal_threshold_ff <= reg_wdata;
                ADDR_NEG_RECAL_LIMIT: negative_recal_count_limit_ff <= reg_wdata;
                ADDR_HYST_PERCENT: touch_hysteresis_percent_ff <= reg_wdata;
                ADDR_HELD_TIMEOUT: held_touch_timeout_ff <= reg_wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rdata_ff <= 8'h00;
        end else begin
            case (reg_addr)
                ADDR_BUTTON_CONFIG: rdata_ff <= button_config_ff;
                ADDR_AVG_HOLD_THR: rdata_ff <= average_hold_threshold_ff;
                ADDR_NEG_RECAL_THR: rdata_ff <= negative_recal_threshold_ff;
                ADDR_NEG_RECAL_LIMIT: rdata_ff <= negative_recal_count_limit_ff;
                ADDR_HYST_PERCENT: rdata_ff <= touch_hysteresis_percent_ff;
                ADDR_HELD_TIMEOUT: rdata_ff <= held_touch_timeout_ff;
                default: rdata_ff <= 8'h00;
            endcase
        end
    end

    assign reg_rdata = rdata_ff;

    // ==========================================================
    // one second tick
    logic [31:0] sec_cnt_ff;
    logic sec_pulse_ff;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sec_cnt_ff <= 32'h00000000;
            sec_pulse_ff <= 1'b0;
        end else if (sec_cnt_ff >= 32'(CYC_PER_SEC - 1)) begin
            sec_cnt_ff <= 32'h00000000;
            sec_pulse_ff <= 1'b1;
        end else begin
            sec_cnt_ff <= sec_cnt_ff + 32'h00000001;
            sec_pulse_ff <= 1'b0;
        end
    end

    // ==========================================================
    // per sensor decision
    logic [1:0] tch_deb;
    logic [1:0] rel_deb;
    logic [7:0] pct_clamped;
    logic [N-1:0] det_vec;
    logic [N-1:0] eff_vec;
    logic [N-1:0] avg_vec;
    logic [N-1:0] neg_fire_vec;

    assign tch_deb = button_config_ff[CFG_TCH_LSB +: 2];
    assign rel_deb = button_config_ff[CFG_REL_LSB +: 2];
    assign pct_clamped = (touch_hysteresis_percent_ff > PCT_MAX) ?
        PCT_MAX : touch_hysteresis_percent_ff;

    genvar gi;
    generate
        for (gi = 0; gi < N; gi = gi + 1) begin : g_sensor
            logic det_ff;
            logic [1:0] cnt_ff;
            logic stuck_ff;
            logic [7:0] stuck_sec_ff;
            logic [7:0] negcnt_ff;
            logic avg_ff;
            logic neg_fire_ff;
            logic above_touch;
            logic below_rel;
            logic above_avg;
            logic below_neg;
            logic [2:0] sens;

            assign sens = sensing_misc_control[MISC_INDIV_BIT] ?
                sensitivity_pairs[(gi ^ 1)*SENS_W +: 3] :
                sensitivity_pairs[COMMON_SENS_LSB +: 3];

            always_comb begin
                int tk;
                int ceil_t;
                int thr_t;
                int hyst;
                tk = int'($signed(sample_ticks[gi*TW +: TW]));
                ceil_t = (int'(sens) + 1) * TICK_STEP;
                if (tk > ceil_t) begin
                    tk = ceil_t;
                end
                thr_t = int'(per_pin_touch_threshold[gi*8 +: 8])
                    * TICKS_PER_CODE;
                hyst = (thr_t * int'(pct_clamped)) / PCT_DIV;
                above_touch = tk > (thr_t + hyst);
                below_rel = tk < (thr_t - hyst);
                above_avg = tk > (int'(average_hold_threshold_ff)
                    * TICKS_PER_CODE);
                below_neg = tk < -(int'(negative_recal_threshold_ff)
                    * TICKS_PER_CODE);
            end

            always_ff @(posedge clk) begin
                if (!rst_b) begin
                    det_ff <= 1'b0;
                    cnt_ff <= 2'h0;
                end else if (scan_sample) begin
                    if (!det_ff) begin
                        if (above_touch) begin
                            if (cnt_ff >= tch_deb) begin
                                det_ff <= 1'b1;
                                cnt_ff <= 2'h0;
                            end else begin
                                cnt_ff <= cnt_ff + 2'h1;
                            end
                        end else begin
                            cnt_ff <= 2'h0;
                        end
                    end else begin
                        if (below_rel) begin
                            if (cnt_ff >= rel_deb) begin
                                det_ff <= 1'b0;
                                cnt_ff <= 2'h0;
                            end else begin
                                cnt_ff <= cnt_ff + 2'h1;
                            end
                        end else begin
                            cnt_ff <= 2'h0;
                        end
                    end
                end
            end

            always_ff @(posedge clk) begin
                if (!rst_b) begin
                    stuck_ff <= 1'b0;
                    stuck_sec_ff <= 8'h00;
                end else if (!det_ff) begin
                    stuck_ff <= 1'b0;
                    stuck_sec_ff <= 8'h00;
                end else if (sec_pulse_ff && !stuck_ff &&
                             held_touch_timeout_ff != 8'h00) begin
                    if (stuck_sec_ff + 8'h01 >= held_touch_timeout_ff) begin
                        stuck_ff <= 1'b1;
                    end else begin
                        stuck_sec_ff <= stuck_sec_ff + 8'h01;
                    end
                end
            end

            always_ff @(posedge clk) begin
                if (!rst_b) begin
                    negcnt_ff <= 8'h00;
                    neg_fire_ff <= 1'b0;
                end else if (scan_sample) begin
                    if (below_neg) begin
                        if (negcnt_ff + 8'h01 >=
                            negative_recal_count_limit_ff) begin
                            negcnt_ff <= 8'h00;
                            neg_fire_ff <= 1'b1;
                        end else begin
                            negcnt_ff <= negcnt_ff + 8'h01;
                            neg_fire_ff <= 1'b0;
                        end
                    end else begin
                        negcnt_ff <= 8'h00;
                        neg_fire_ff <= 1'b0;
                    end
                end else begin
                    neg_fire_ff <= 1'b0;
                end
            end

            always_ff @(posedge clk) begin
                if (!rst_b) begin
                    avg_ff <= 1'b0;
                end else if (scan_sample) begin
                    avg_ff <= above_avg;
                end
            end

            assign det_vec[gi] = det_ff;
            assign eff_vec[gi] = det_ff & ~stuck_ff;
            assign avg_vec[gi] = avg_ff;
            assign neg_fire_vec[gi] = neg_fire_ff;
        end
    endgenerate

    // ==========================================================
    // reporting
    trd_rpt_state_t rpt_state_ff;
    trd_rpt_state_t nxt_rpt_state;
    logic [N-1:0] lock_mask_ff;
    logic [N-1:0] nxt_lock_mask;
    logic [N-1:0] btn_ff;
    logic [N-1:0] nxt_btn;
    logic [N-1:0] avail;
    logic [N-1:0] lowest;
    logic irq_ff;
    logic [1:0] irq_sel;

    // touches held over from a lock stay ignored until released
    assign avail = eff_vec & ~lock_mask_ff;
    assign lowest = avail & (~avail + N'(1));
    assign irq_sel = button_config_ff[CFG_IRQ_LSB +: 2];

    always_comb begin
        nxt_rpt_state = rpt_state_ff;
        nxt_lock_mask = lock_mask_ff;
        nxt_btn = eff_vec;
        if (button_config_ff[CFG_RPT_LSB +: 2] == RPT_FIRST) begin
            case (rpt_state_ff)
                RPT_FREE: begin
                    nxt_btn = lowest;
                    nxt_lock_mask = lock_mask_ff & eff_vec;
                    if (avail != '0) begin
                        nxt_rpt_state = RPT_LOCKED;
                        nxt_lock_mask = lowest;
                    end
                end
                RPT_LOCKED: begin
                    nxt_btn = eff_vec & lock_mask_ff;
                    if ((eff_vec & lock_mask_ff) == '0) begin
                        nxt_rpt_state = RPT_FREE;
                        nxt_lock_mask = eff_vec;
                    end
                end
                default: begin
                    nxt_rpt_state = RPT_FREE;
                    nxt_lock_mask = '0;
                    nxt_btn = '0;
                end
            endcase
        end else begin
            nxt_rpt_state = RPT_FREE;
            nxt_lock_mask = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rpt_state_ff <= RPT_FREE;
            lock_mask_ff <= '0;
            btn_ff <= '0;
        end else begin
            rpt_state_ff <= nxt_rpt_state;
            lock_mask_ff <= nxt_lock_mask;
            btn_ff <= nxt_btn;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= (irq_sel[IRQ_TOUCH_BIT] && (nxt_btn & ~btn_ff) != '0)
                || (irq_sel[IRQ_RELEASE_BIT] && (~nxt_btn & btn_ff) != '0);
        end
    end

    // ==========================================================
    // recalibration requests
    logic [5:0] per_sec_ff;
    logic [5:0] per_target;
    logic per_fire;
    logic recal_ff;

    always_comb begin
        if (periodic_recal_interval <= PER_LINEAR_MAX) begin
            per_target = 6'(periodic_recal_interval);
        end else if (periodic_recal_interval == PER_LONG_CODE) begin
            per_target = 6'(PER_LONG_SEC);
        end else begin
            per_target = 6'(PER_BASE_SEC + PER_STEP_SEC *
                (int'(periodic_recal_interval) - int'(PER_LINEAR_MAX) - 1));
        end
    end

    assign per_fire = (per_target != 6'h00) && (per_sec_ff >= per_target)
        && (det_vec == '0);

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            per_sec_ff <= 6'h00;
        end else if (per_target == 6'h00 || per_fire) begin
            per_sec_ff <= 6'h00;
        end else if (sec_pulse_ff && per_sec_ff < per_target) begin
            per_sec_ff <= per_sec_ff + 6'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            recal_ff <= 1'b0;
        end else begin
            recal_ff <= per_fire || (neg_fire_vec != '0) ||
                ($countones(avg_vec) >= MIN_AVG_SENSORS && scan_sample);
        end
    end

    // ==========================================================
    // outputs
    assign button_state = btn_ff;
    assign button_irq = irq_ff;
    assign average_hold = avg_vec;
    assign recal_request = recal_ff;

endmodule

// File: trd_core_props.sv
// assertions for the touch and release decision core
`timescale 1ns/10ps
module trd_core_props #(
    parameter int N = 8,
    parameter int TW = 14
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic [7:0] reg_rdata,
    // sensing
    input wire logic scan_sample,
    input wire logic [N*TW-1:0] sample_ticks,
    input wire logic [3:0] periodic_recal_interval,
    // results
    input wire logic [N-1:0] button_state,
    input wire logic button_irq,
    input wire logic [N-1:0] average_hold,
    input wire logic recal_request
);
    import trd_pkg::*;
    logic [7:0] cfg_ff;
    logic [7:0] avg_ff;
    logic signed [TW-1:0] t0;
    logic signed [TW-1:0] hold_lvl;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    assign t0 = sample_ticks[TW-1:0];
    assign hold_lvl = TW'({avg_ff, 2'b00});

    // ==========================================================
    // shadow registers
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cfg_ff <= RST_BUTTON_CONFIG;
            avg_ff <= RST_AVG_HOLD_THR;
        end else if (reg_wr) begin
            if (reg_addr == ADDR_BUTTON_CONFIG) cfg_ff <= reg_wdata;
            if (reg_addr == ADDR_AVG_HOLD_THR) avg_ff <= reg_wdata;
        end
    end

    // ==========================================================
    // properties
    // config readback
    property p_cfg_read;
        reg_addr == ADDR_BUTTON_CONFIG && !reg_wr |=> reg_rdata == $past(cfg_ff);
    endproperty
    property p_first_only;
        cfg_ff[7:6] == RPT_FIRST |-> $countones(button_state) <= 1;
    endproperty
    property p_irq_mask;
        cfg_ff[5:4] == 2'b00 |-> !button_irq;
    endproperty
    property p_irq_touch;
        cfg_ff[4] && |(button_state & ~$past(button_state)) |-> button_irq;
    endproperty
    property p_irq_cause;
        button_irq |-> button_state != $past(button_state);
    endproperty
    property p_rise_sample;
        |(button_state & ~$past(button_state)) |-> $past(scan_sample, 2);
    endproperty
    property p_hold_sample;
        !$stable(average_hold) |-> $past(scan_sample);
    endproperty
    property p_hold_set;
        scan_sample && t0 > hold_lvl && t0 < 1000 |=> average_hold[0];
    endproperty
    property p_recal;
        recal_request && periodic_recal_interval == 4'h0
            |-> $past(scan_sample) || $past(scan_sample, 2);
    endproperty

    a_cfg_read: assert property (p_cfg_read)
        else $error("config readback differs");
    a_first_only: assert property (p_first_only)
        else $error("more than one button in single mode");
    a_irq_mask: assert property (p_irq_mask)
        else $error("interrupt while masked");
    a_irq_touch: assert property (p_irq_touch)
        else $error("touch without interrupt");
    a_irq_cause: assert property (p_irq_cause)
        else $error("interrupt without state change");
    a_rise_sample: assert property (p_rise_sample)
        else $error("touch not two edges after sample");
    a_hold_sample: assert property (p_hold_sample)
        else $error("hold changed without sample");
    a_hold_set: assert property (p_hold_set)
        else $error("hold not set above level");
    a_recal: assert property (p_recal)
        else $error("recal request out of step");

    c_touch: cover property (button_irq && |button_state);
    c_recal: cover property (recal_request);
    c_hold: cover property ($rose(average_hold[3]));
endmodule

bind trd_core trd_core_props #(.N(N), .TW(TW)) i_props (
    .clk(clk),
    .rst_b(rst_b),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rdata(reg_rdata),
    .scan_sample(scan_sample),
    .sample_ticks(sample_ticks),
    .periodic_recal_interval(periodic_recal_interval),
    .button_state(button_state),
    .button_irq(button_irq),
    .average_hold(average_hold),
    .recal_request(recal_request)
);

// File: trd_core_tb.sv
// self-checking bench for the touch and release decision core
`timescale 1ns/10ps
module trd_core_tb;
    import trd_pkg::*;
    localparam int VW = 8 * TICK_W;
    logic clk, rst_b, reg_wr, scan_sample, button_irq, recal_request;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, button_state, average_hold;
    logic [VW-1:0] sample_ticks;
    logic [31:0] sens;
    logic [7:0] misc;
    logic [3:0] per_iv;
    logic [15:0] irq_n, rec_n, ic, rc;
    int err_count, total_checks, m;
    logic [7:0] rst_tab [7] = '{8'h30, 8'h50, 8'h50, 8'h01, 8'h0A,
        8'h00, 8'h00};

    // ==========================================================
    // design and host
    trd_core #(.CYC_PER_SEC(20)) i_dut (
        .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata),
        .scan_sample(scan_sample), .sample_ticks(sample_ticks),
        .per_pin_touch_threshold({{6{8'h10}}, 8'h20, 8'h10}),
        .sensitivity_pairs(sens), .sensing_misc_control(misc),
        .periodic_recal_interval(per_iv), .button_state(button_state),
        .button_irq(button_irq), .average_hold(average_hold),
        .recal_request(recal_request));
    trd_host_model i_host (.clk(clk), .rst_b(rst_b),
        .button_irq(button_irq), .recal_request(recal_request),
        .irq_cnt_ff(irq_n), .rec_cnt_ff(rec_n));

    // ==========================================================
    // helpers
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    function automatic logic [VW-1:0] tk(input int s, input int v);
        tk = '0;
        tk[s*TICK_W+:TICK_W] = v[TICK_W-1:0];
    endfunction
    task check(input string nm, input logic [15:0] seen,
            input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        reg_addr = a;
        @(negedge clk);
        check("rdata", {8'h00, reg_rdata}, {8'h00, exp});
    endtask
    task smp(input logic [VW-1:0] v);
        @(negedge clk);
        sample_ticks = v;
        scan_sample = 1'b1;
        @(negedge clk);
        scan_sample = 1'b0;
        repeat (3) @(negedge clk);
    endtask
    task bs(input logic [7:0] exp);
        check("button_state", {8'h00, button_state}, {8'h00, exp});
    endtask
    task report_and_stop();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        report_and_stop();
    end

    // ==========================================================
    // tests
    initial begin
        {rst_b, reg_wr, scan_sample, reg_addr, reg_wdata} = '0;
        sample_ticks = '0;
        sens = 32'h7777_7777;
        misc = 8'h00;
        per_iv = 4'h0;
        err_count = 0;
        total_checks = 0;
        repeat (8) @(negedge clk);
        rst_b = 1'b1;
        for (m = 0; m < 7; m++) rd(8'h21 + m[7:0], rst_tab[m]);
        wr(ADDR_BUTTON_CONFIG, 8'h31);
        rd(ADDR_BUTTON_CONFIG, 8'h31);
        ic = irq_n;
        smp(tk(0, 70) | tk(1, 141));
        smp(tk(0, 71) | tk(1, 140));
        bs(8'h00);
        smp(tk(0, 71) | tk(1, 140));
        bs(8'h01);
        check("irq", irq_n - ic, 16'h1);
        smp(tk(0, 58));
        bs(8'h01);
        smp(tk(0, 57));
        bs(8'h00);
        wr(ADDR_BUTTON_CONFIG, 8'h3F);
        repeat (3) smp(tk(0, 100));
        bs(8'h00);
        smp(tk(0, 100));
        bs(8'h01);
        repeat (3) smp('0);
        bs(8'h01);
        smp('0);
        bs(8'h00);
        wr(ADDR_BUTTON_CONFIG, 8'h30);
        wr(ADDR_HYST_PERCENT, 8'h00);
        smp(tk(0, 65));
        smp(tk(0, 64));
        bs(8'h01);
        smp(tk(0, 63));
        bs(8'h00);
        wr(ADDR_HYST_PERCENT, 8'h0F);
        smp(tk(0, 73));
        bs(8'h00);
        smp(tk(0, 74));
        bs(8'h01);
        smp('0);
        for (m = 0; m < 4; m++) begin
            wr(ADDR_BUTTON_CONFIG, {2'b00, m[1:0], 4'h0});
            ic = irq_n;
            smp(tk(0, 100));
            check("irq_t", irq_n - ic, 16'(m[0]));
            smp('0);
            check("irq_r", irq_n - ic, 16'(m[0]) + 16'(m[1]));
        end
        wr(ADDR_BUTTON_CONFIG, 8'h70);
        smp(tk(1, 200));
        smp(tk(1, 200) | tk(2, 200));
        bs(8'h02);
        smp(tk(2, 200));
        bs(8'h00);
        smp('0);
        wr(ADDR_BUTTON_CONFIG, 8'h30);
        smp(tk(1, 200) | tk(2, 200));
        bs(8'h06);
        smp('0);
        wr(ADDR_AVG_HOLD_THR, 8'h10);
        smp(tk(3, 65));
        check("hold", {8'h00, average_hold}, 16'h0008);
        smp(tk(3, 64));
        check("hold", {8'h00, average_hold}, 16'h0000);
        rc = rec_n;
        smp(tk(2, 65) | tk(3, 65));
        smp('0);
        check("recal", rec_n - rc, 16'h0);
        smp(tk(2, 65) | tk(3, 65) | tk(4, 65));
        smp('0);
        check("recal", rec_n - rc, 16'h1);
        wr(ADDR_NEG_RECAL_THR, 8'h10);
        wr(ADDR_NEG_RECAL_LIMIT, 8'h02);
        rc = rec_n;
        smp(tk(0, -64) | tk(1, -65));
        check("recal", rec_n - rc, 16'h0);
        smp(tk(1, -65));
        check("recal", rec_n - rc, 16'h1);
        smp('0);
        wr(ADDR_HELD_TIMEOUT, 8'h01);
        ic = irq_n;
        smp(tk(0, 100));
        repeat (45) @(negedge clk);
        bs(8'h00);
        check("irq", irq_n - ic, 16'h2);
        smp(tk(0, 100));
        bs(8'h00);
        smp('0);
        wr(ADDR_HELD_TIMEOUT, 8'h00);
        smp(tk(0, 100));
        bs(8'h01);
        rc = rec_n;
        per_iv = 4'h2;
        repeat (60) @(negedge clk);
        check("recal", rec_n - rc, 16'h0);
        smp('0);
        check("recal", rec_n - rc, 16'h1);
        per_iv = 4'h0;
        @(negedge clk);
        per_iv = 4'h9;
        rc = rec_n;
        repeat (330) @(negedge clk);
        check("recal", rec_n - rc, 16'h0);
        repeat (40) @(negedge clk);
        check("recal", rec_n - rc, 16'h1);
        per_iv = 4'h0;
        sens = 32'h0000_0700;
        wr(ADDR_AVG_HOLD_THR, 8'hFF);
        smp(tk(3, 2000));
        check("hold", {8'h00, average_hold}, 16'h0000);
        misc = 8'h04;
        smp(tk(3, 2000));
        check("hold", {8'h00, average_hold}, 16'h0008);
        report_and_stop();
    end
endmodule

// File: trd_host_model.sv
// host-side event tally for the decision core
`timescale 1ns/10ps
module trd_host_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // device events
    input wire logic button_irq,
    input wire logic recal_request,
    // tallies
    output logic [15:0] irq_cnt_ff,
    output logic [15:0] rec_cnt_ff
);
    // ==========================================================
    // event counting
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            irq_cnt_ff <= 16'h0000;
            rec_cnt_ff <= 16'h0000;
        end else begin
            irq_cnt_ff <= irq_cnt_ff + 16'(button_irq);
            rec_cnt_ff <= rec_cnt_ff + 16'(recal_request);
        end
    end
endmodule

// File: trd_pkg.sv
// constants and types for the touch and release decision block
package trd_pkg;

    // ==========================================================
    // sizes
    localparam int NUM_SENSORS = 8;
    localparam int TICK_W = 14;
    localparam int SENS_W = 4;

    // ==========================================================
    // register offsets
    localparam logic [7:0] ADDR_BUTTON_CONFIG = 8'h21;
    localparam logic [7:0] ADDR_AVG_HOLD_THR = 8'h22;
    localparam logic [7:0] ADDR_NEG_RECAL_THR = 8'h23;
    localparam logic [7:0] ADDR_NEG_RECAL_LIMIT = 8'h24;
    localparam logic [7:0] ADDR_HYST_PERCENT = 8'h25;
    localparam logic [7:0] ADDR_HELD_TIMEOUT = 8'h26;

    // ==========================================================
    // reset values
    localparam logic [7:0] RST_BUTTON_CONFIG = 8'h30;
    localparam logic [7:0] RST_AVG_HOLD_THR = 8'h50;
    localparam logic [7:0] RST_NEG_RECAL_THR = 8'h50;
    localparam logic [7:0] RST_NEG_RECAL_LIMIT = 8'h01;
    localparam logic [7:0] RST_HYST_PERCENT = 8'h0A;
    localparam logic [7:0] RST_HELD_TIMEOUT = 8'h00;

    // ==========================================================
    // field positions and codes
    localparam int CFG_RPT_LSB = 6;
    localparam int CFG_IRQ_LSB = 4;
    localparam int CFG_REL_LSB = 2;
    localparam int CFG_TCH_LSB = 0;
    localparam int MISC_INDIV_BIT = 2;
    localparam int COMMON_SENS_LSB = 4;
    localparam logic [1:0] RPT_MULTI = 2'h0;
    localparam logic [1:0] RPT_FIRST = 2'h1;
    localparam int IRQ_TOUCH_BIT = 0;
    localparam int IRQ_RELEASE_BIT = 1;

    // ==========================================================
    // scaling
    localparam int TICKS_PER_CODE = 4;
    localparam int PCT_DIV = 100;
    localparam logic [7:0] PCT_MAX = 8'h64;
    localparam int TICK_STEP = 1000;
    localparam int MIN_AVG_SENSORS = 3;
    localparam logic [3:0] PER_LINEAR_MAX = 4'h7;
    localparam logic [3:0] PER_LONG_CODE = 4'hF;
    localparam int PER_BASE_SEC = 16;
    localparam int PER_STEP_SEC = 2;
    localparam int PER_LONG_SEC = 60;

    // ==========================================================
    // timing
    localparam int SECOND_NS = 1000000000;
    localparam int CLK_PERIOD_NS = 25;
    localparam int CYCLES_PER_SECOND = SECOND_NS / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        RPT_FREE = 2'b01,
        RPT_LOCKED = 2'b10
    } trd_rpt_state_t;

endpackage
